// ---- fps_pkg.sv ----
package fps_pkg;

   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;

   // Control register fields
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_OVERVOLTAGE_DISABLE_BIT = 1;
   localparam int CTRL_UNDERVOLTAGE_DISABLE_BIT = 2;
   localparam int CTRL_OPEN_LOAD_DISABLE_BIT = 3;
   localparam int CTRL_LOW_SEL_LSB = 4;
   localparam int CTRL_HIGH_SEL_BIT = 7;
   localparam int CTRL_BLANK_SEL_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Status register fields: sticky flags low, live state above
   localparam int NUM_FLAGS = 5;
   localparam int ST_OVERTEMP = 0;
   localparam int ST_OVERVOLTAGE = 1;
   localparam int ST_UNDERVOLTAGE = 2;
   localparam int ST_OPEN_LOAD = 3;
   localparam int ST_OVERCURRENT = 4;
   localparam int ST_OUT_ON = 8;
   localparam int ST_FAULT_N = 9;
   localparam int ST_UV_LATCH = 10;
   localparam int ST_OC_LATCH = 11;

   // Over-current blanking times, selectable by two control bits
   localparam int CLK_PERIOD_NS = 4;
   localparam int BLANK_T0_NS = 2000;
   localparam int BLANK_T1_NS = 4000;
   localparam int BLANK_T2_NS = 8000;
   localparam int BLANK_T3_NS = 16000;
   localparam int BLANK_W = 12;
   localparam logic [BLANK_W-1:0] BLANK_C0 =
      BLANK_W'((BLANK_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [BLANK_W-1:0] BLANK_C1 =
      BLANK_W'((BLANK_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [BLANK_W-1:0] BLANK_C2 =
      BLANK_W'((BLANK_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [BLANK_W-1:0] BLANK_C3 =
      BLANK_W'((BLANK_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef struct packed {
      logic spi_on;
      logic overvoltage_disable;
      logic undervoltage_disable;
      logic open_load_disable;
      logic [2:0] low_sel;
      logic high_sel;
      logic [1:0] blank_sel;
      logic [NUM_FLAGS-1:0] flags;
      logic uv_latch;
      logic oc_latch;
      logic [BLANK_W-1:0] blank_cnt;
      logic out_on;
      logic fault_n;
      logic ready;
      logic [31:0] rdata;
   } fps_state_s;

   localparam fps_state_s STATE_RESET = '{
      spi_on: 1'b0, overvoltage_disable: 1'b0, undervoltage_disable: 1'b0,
      open_load_disable: 1'b0, low_sel: 3'h0, high_sel: 1'b0, blank_sel: 2'h0,
      flags: 5'h00, uv_latch: 1'b0, oc_latch: 1'b0, blank_cnt: 12'h000,
      out_on: 1'b0, fault_n: 1'b1, ready: 1'b0, rdata: 32'h0000_0000};

endpackage

// ---- fps_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none

module fps_supervisor
#(
   parameter int LOW_LEVELS = 8,
   parameter int HIGH_LEVELS = 2
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic logic_supply_ok,
   input wire logic direct_in,
   input wire logic overtemp_hot,
   input wire logic overvoltage_det,
   input wire logic battery_low_threshold,
   input wire logic battery_below_2v5,
   input wire logic open_load_det,
   input wire logic gate_discharged,
   input wire logic [LOW_LEVELS-1:0] low_overcurrent_level,
   input wire logic [HIGH_LEVELS-1:0] high_overcurrent_level,
   output logic output_on,
   output logic fault_indicator_n
);

   fps_pkg::fps_state_s s_q;
   fps_pkg::fps_state_s s_d;

   logic cmd_on;
   logic ot_shut;
   logic ov_act;
   logic uv_act;
   logic uv_fault;
   logic ol_act;
   logic low_hit;
   logic high_hit;
   logic blank_done;
   logic [fps_pkg::NUM_FLAGS-1:0] flag_set;
   logic acc_done;
   logic status_read;

   function automatic logic [fps_pkg::BLANK_W-1:0] blank_cycles(input logic [1:0] sel);
      case (sel)
         2'h0: blank_cycles = fps_pkg::BLANK_C0;
         2'h1: blank_cycles = fps_pkg::BLANK_C1;
         2'h2: blank_cycles = fps_pkg::BLANK_C2;
         default: blank_cycles = fps_pkg::BLANK_C3;
      endcase
   endfunction

   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == fps_pkg::ADDR_CTRL) || (a == fps_pkg::ADDR_STATUS);
   endfunction

   // Either source turns the switch on
   assign cmd_on = direct_in | s_q.spi_on;
   assign ot_shut = overtemp_hot & cmd_on;
   assign ov_act = overvoltage_det & ~s_q.overvoltage_disable;
   assign uv_act = battery_low_threshold & ~s_q.undervoltage_disable;
   // Dropping the command frees the pin in the same cycle it frees the latch
   assign uv_fault = uv_act | (s_q.uv_latch & cmd_on);
   // Only sampled once the gate is low, so a slow turn-off is not misread
   assign ol_act = ~s_q.out_on & gate_discharged & open_load_det
                   & ~s_q.open_load_disable;
   assign low_hit = low_overcurrent_level[s_q.low_sel] & s_q.out_on;
   assign high_hit = high_overcurrent_level[s_q.high_sel] & s_q.out_on;
   assign blank_done = s_q.blank_cnt >= blank_cycles(s_q.blank_sel) - 12'h001;

   assign flag_set[fps_pkg::ST_OVERTEMP] = ot_shut;
   assign flag_set[fps_pkg::ST_OVERVOLTAGE] = ov_act;
   assign flag_set[fps_pkg::ST_UNDERVOLTAGE] = uv_act;
   assign flag_set[fps_pkg::ST_OPEN_LOAD] = ol_act;
   assign flag_set[fps_pkg::ST_OVERCURRENT] = high_hit | (low_hit & blank_done);

   assign acc_done = psel & penable & s_q.ready;
   assign status_read = acc_done & ~pwrite & (paddr == fps_pkg::ADDR_STATUS);

   always_comb
   begin
      s_d = s_q;
      s_d.ready = psel & penable & ~s_q.ready;
      // Read data is captured one cycle before completion
      if (psel && penable && !s_q.ready)
      begin
         s_d.rdata = 32'h0000_0000;
         if (!pwrite && paddr == fps_pkg::ADDR_CTRL)
         begin
            s_d.rdata[fps_pkg::CTRL_ON_BIT] = s_q.spi_on;
            s_d.rdata[fps_pkg::CTRL_OVERVOLTAGE_DISABLE_BIT] = s_q.overvoltage_disable;
            s_d.rdata[fps_pkg::CTRL_UNDERVOLTAGE_DISABLE_BIT] = s_q.undervoltage_disable;
            s_d.rdata[fps_pkg::CTRL_OPEN_LOAD_DISABLE_BIT] = s_q.open_load_disable;
            s_d.rdata[fps_pkg::CTRL_LOW_SEL_LSB +: 3] = s_q.low_sel;
            s_d.rdata[fps_pkg::CTRL_HIGH_SEL_BIT] = s_q.high_sel;
            s_d.rdata[fps_pkg::CTRL_BLANK_SEL_LSB +: 2] = s_q.blank_sel;
         end
         else if (!pwrite && paddr == fps_pkg::ADDR_STATUS)
         begin
            s_d.rdata[fps_pkg::NUM_FLAGS-1:0] = s_q.flags;
            s_d.rdata[fps_pkg::ST_OUT_ON] = s_q.out_on;
            s_d.rdata[fps_pkg::ST_FAULT_N] = s_q.fault_n;
            s_d.rdata[fps_pkg::ST_UV_LATCH] = s_q.uv_latch;
            s_d.rdata[fps_pkg::ST_OC_LATCH] = s_q.oc_latch;
         end
      end
      if (acc_done && pwrite && paddr == fps_pkg::ADDR_CTRL)
      begin
         s_d.spi_on = pwdata[fps_pkg::CTRL_ON_BIT];
         s_d.overvoltage_disable = pwdata[fps_pkg::CTRL_OVERVOLTAGE_DISABLE_BIT];
         s_d.undervoltage_disable = pwdata[fps_pkg::CTRL_UNDERVOLTAGE_DISABLE_BIT];
         s_d.open_load_disable = pwdata[fps_pkg::CTRL_OPEN_LOAD_DISABLE_BIT];
         s_d.low_sel = pwdata[fps_pkg::CTRL_LOW_SEL_LSB +: 3];
         s_d.high_sel = pwdata[fps_pkg::CTRL_HIGH_SEL_BIT];
         s_d.blank_sel = pwdata[fps_pkg::CTRL_BLANK_SEL_LSB +: 2];
      end

      // Only flags that were actually reported are cleared; a new set wins
      if (status_read)
      begin
         s_d.flags = s_q.flags & ~s_q.rdata[fps_pkg::NUM_FLAGS-1:0];
      end
      s_d.flags = s_d.flags | flag_set;

      // Under-voltage latches only when commanded on; off releases it
      if (!cmd_on)
      begin
         s_d.uv_latch = 1'b0;
      end
      else if (uv_act)
      begin
         s_d.uv_latch = 1'b1;
      end

      if (low_hit)
      begin
         s_d.blank_cnt = s_q.blank_cnt + 12'h001;
      end
      else
      begin
         s_d.blank_cnt = 12'h000;
      end
      if (!cmd_on)
      begin
         s_d.oc_latch = 1'b0;
      end
      else if (high_hit || (low_hit && blank_done))
      begin
         s_d.oc_latch = 1'b1;
      end

      // Over-temperature gates the output directly, so it self-recovers
      s_d.out_on = cmd_on & ~ot_shut & ~ov_act & ~uv_fault & ~s_d.oc_latch
                   & ~battery_below_2v5;
      s_d.fault_n = ~(ot_shut | ov_act | uv_fault | ol_act | s_d.oc_latch);

      // A lost logic supply wipes configuration and flags; defaults keep
      // every protection path alive, and the direct input still drives
      if (!logic_supply_ok)
      begin
         s_d.spi_on = fps_pkg::CTRL_RESET[fps_pkg::CTRL_ON_BIT];
         s_d.overvoltage_disable = fps_pkg::CTRL_RESET[fps_pkg::CTRL_OVERVOLTAGE_DISABLE_BIT];
         s_d.undervoltage_disable = fps_pkg::CTRL_RESET[fps_pkg::CTRL_UNDERVOLTAGE_DISABLE_BIT];
         s_d.open_load_disable = fps_pkg::CTRL_RESET[fps_pkg::CTRL_OPEN_LOAD_DISABLE_BIT];
         s_d.low_sel = fps_pkg::CTRL_RESET[fps_pkg::CTRL_LOW_SEL_LSB +: 3];
         s_d.high_sel = fps_pkg::CTRL_RESET[fps_pkg::CTRL_HIGH_SEL_BIT];
         s_d.blank_sel = fps_pkg::CTRL_RESET[fps_pkg::CTRL_BLANK_SEL_LSB +: 2];
         s_d.flags = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= fps_pkg::STATE_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.ready & ~addr_mapped(paddr);
   assign output_on = s_q.out_on;
   assign fault_indicator_n = s_q.fault_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_uv_trip;
      uv_act && cmd_on && logic_supply_ok;
   endsequence

   sequence s_cmd_held;
      cmd_on[*3];
   endsequence

   sequence s_oc_trip;
      high_hit && cmd_on;
   endsequence

   a_supply_loss_cfg: assert property (!logic_supply_ok |=> !s_q.spi_on && s_q.low_sel == 3'h0)
      else $error("config not defaulted on supply loss");

   a_fault_pin_ot: assert property (ot_shut |=> !fault_indicator_n)
      else $error("fault pin high during over-temperature");

   a_pin_release: assert property (
      !cmd_on && !overtemp_hot && !overvoltage_det && !battery_low_threshold
      && !open_load_det |=> fault_indicator_n)
      else $error("fault pin not released after fault cleared");

   a_flag_read_clear: assert property (
      status_read && s_q.rdata[fps_pkg::ST_OPEN_LOAD] && !ol_act && logic_supply_ok
      |=> !s_q.flags[fps_pkg::ST_OPEN_LOAD])
      else $error("reported flag not cleared by read");

   a_ot_only_on: assert property ($rose(s_q.flags[fps_pkg::ST_OVERTEMP]) |-> $past(cmd_on))
      else $error("over-temperature flagged while commanded off");

   a_ot_recover: assert property (
      ot_shut ##1 (cmd_on && !overtemp_hot && !overvoltage_det && !battery_low_threshold
      && !battery_below_2v5 && !s_q.oc_latch && !s_q.uv_latch && !low_hit && !high_hit)
      |=> output_on)
      else $error("output did not return after over-temperature");

   a_ov_shut: assert property (overvoltage_det && !s_q.overvoltage_disable |=> !output_on)
      else $error("output on during over-voltage");

   a_ov_quiet: assert property (
      $rose(s_q.flags[fps_pkg::ST_OVERVOLTAGE]) |-> !$past(s_q.overvoltage_disable))
      else $error("over-voltage reported while disabled");

   a_uv_latched: assert property (s_uv_trip ##1 s_cmd_held |-> !output_on && !fault_indicator_n)
      else $error("under-voltage latch released while command on");

   a_uv_disabled: assert property (
      $rose(s_q.flags[fps_pkg::ST_UNDERVOLTAGE]) |-> !$past(s_q.undervoltage_disable))
      else $error("under-voltage reported while disabled");

   a_ol_when_off: assert property ($rose(s_q.flags[fps_pkg::ST_OPEN_LOAD]) |-> !$past(output_on))
      else $error("open load flagged while output on");

   a_oc_high_now: assert property (high_hit && cmd_on |=> s_q.oc_latch ##0 !output_on)
      else $error("high over-current not latched at once");

   a_oc_blank: assert property (
      $rose(s_q.oc_latch) && !$past(high_hit)
      |-> $past(s_q.blank_cnt) + 12'h001 >= blank_cycles($past(s_q.blank_sel)))
      else $error("low over-current latched before blanking time");

   a_oc_stay: assert property (s_q.oc_latch && cmd_on |=> s_q.oc_latch && !output_on)
      else $error("over-current latch dropped without off command");

   a_uv_trip_off: assert property (uv_act |=> !output_on && !fault_indicator_n)
      else $error("under-voltage did not switch off");

   a_uv_flag_set: assert property (uv_act && logic_supply_ok
      |=> s_q.flags[fps_pkg::ST_UNDERVOLTAGE])
      else $error("under-voltage flag not set");

   a_uv_flag_hold: assert property (s_q.flags[fps_pkg::ST_UNDERVOLTAGE]
      && !status_read && logic_supply_ok |=> s_q.flags[fps_pkg::ST_UNDERVOLTAGE])
      else $error("under-voltage flag lost before read");

   a_low_batt_off: assert property (battery_below_2v5 |=> !output_on)
      else $error("output on below 2.5 V");

   a_ol_disabled: assert property ($rose(s_q.flags[fps_pkg::ST_OPEN_LOAD])
      |-> !$past(s_q.open_load_disable))
      else $error("open load reported while disabled");

   a_ot_shut_off: assert property (ot_shut |=> !output_on)
      else $error("output on during over-temperature");

   a_ot_flag_set: assert property (ot_shut && logic_supply_ok
      |=> s_q.flags[fps_pkg::ST_OVERTEMP])
      else $error("over-temperature flag not set");

   a_ot_read_clear: assert property (status_read && s_q.rdata[fps_pkg::ST_OVERTEMP]
      && !ot_shut |=> !s_q.flags[fps_pkg::ST_OVERTEMP])
      else $error("over-temperature flag not cleared by read");

   a_ov_flag_set: assert property (ov_act && logic_supply_ok
      |=> s_q.flags[fps_pkg::ST_OVERVOLTAGE])
      else $error("over-voltage flag not set");

   a_ov_flag_again: assert property (status_read && ov_act && logic_supply_ok
      |=> s_q.flags[fps_pkg::ST_OVERVOLTAGE])
      else $error("persisting over-voltage not flagged again");

   a_ov_pin_low: assert property (ov_act |=> !fault_indicator_n)
      else $error("fault pin high during over-voltage");

   a_ol_pin_low: assert property (ol_act |=> !fault_indicator_n)
      else $error("fault pin high during open load");

   a_latch_pin: assert property (s_q.oc_latch || s_q.uv_latch
      |-> !fault_indicator_n && !output_on)
      else $error("latched fault released the pin");

   a_cmd_off_off: assert property (!cmd_on |=> !output_on)
      else $error("output on without a command");

   a_oc_low_sel: assert property (cmd_on && !s_q.oc_latch && !high_hit
      && !low_overcurrent_level[s_q.low_sel] |=> !s_q.oc_latch)
      else $error("over-current latched on an unselected level");

   a_oc_flag_set: assert property (high_hit && logic_supply_ok
      |=> s_q.flags[fps_pkg::ST_OVERCURRENT])
      else $error("over-current flag not set");

   a_oc_latch_hold: assert property (s_oc_trip ##1 s_cmd_held
      |-> s_q.oc_latch && !output_on)
      else $error("over-current latch released while command on");

   a_supply_flags: assert property (!logic_supply_ok |=> s_q.flags == 5'h00)
      else $error("flags kept on supply loss");

   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no ready after first access cycle");

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held beyond one cycle");

endmodule

`default_nettype wire

// ---- fps_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module fps_host
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // Wait is bounded so that a silent slave ends the run
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         tb_top.check("pready", {31'h0, pready}, 32'h0000_0001);
         tb_top.end_sim();
      end
      else
      begin
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // Released data must not look like the last word
         pwdata <= ~d;
      end
   endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam logic [11:0] CT = fps_pkg::ADDR_CTRL;
   localparam logic [11:0] ST = fps_pkg::ADDR_STATUS;
   logic clk, nrst, ok, di, hot, ov, bl, b25, old, gd, e;
   logic psel, penable, pwrite, pready, pslverr, out_on, fault_n;
   logic [7:0] lo;
   logic [1:0] hi;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int failures = 0;
   int check_count = 0;

   fps_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   fps_supervisor u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .logic_supply_ok(ok), .direct_in(di),
      .overtemp_hot(hot), .overvoltage_det(ov), .battery_low_threshold(bl),
      .battery_below_2v5(b25), .open_load_det(old), .gate_discharged(gd),
      .low_overcurrent_level(lo), .high_overcurrent_level(hi),
      .output_on(out_on), .fault_indicator_n(fault_n));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(input logic [31:0] d);
      u_host.xfer(1'b1, CT, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a);
      u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
   endtask

   task automatic t(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic ck(input logic on, input logic fn);
      check("output_on", {31'h0, out_on}, {31'h0, on});
      check("fault_n", {31'h0, fault_n}, {31'h0, fn});
   endtask

   task automatic fl(input int b, input logic x);
      rd(ST);
      check($sformatf("status_bit%0d", b), {31'h0, q[b]}, {31'h0, x});
   endtask

   task automatic sc_reset();
      rd(CT);
      check("ctrl_reset", q, fps_pkg::CTRL_RESET);
      rd(ST);
      check("status_reset", q, 32'h0000_0001 << fps_pkg::ST_FAULT_N);
      rd(12'h008);
      check("unmapped_err", {31'h0, e}, 32'h0000_0001);
      check("unmapped_data", q, 32'h0000_0000);
   endtask

   task automatic sc_ov();
      wr(32'h0000_0001);
      t(2);
      ck(1'b1, 1'b1);
      @(posedge clk) ov <= 1'b1;
      t(2);
      ck(1'b0, 1'b0);
      fl(fps_pkg::ST_OVERVOLTAGE, 1'b1);
      fl(fps_pkg::ST_OVERVOLTAGE, 1'b1);
      @(posedge clk) ov <= 1'b0;
      t(2);
      ck(1'b1, 1'b1);
      rd(ST);
      fl(fps_pkg::ST_OVERVOLTAGE, 1'b0);
      wr(32'h0000_0003);
      @(posedge clk) ov <= 1'b1;
      t(3);
      ck(1'b1, 1'b1);
      fl(fps_pkg::ST_OVERVOLTAGE, 1'b0);
      @(posedge clk) ov <= 1'b0;
   endtask

   task automatic sc_ot();
      wr(32'h0000_0001);
      @(posedge clk) hot <= 1'b1;
      t(2);
      ck(1'b0, 1'b0);
      fl(fps_pkg::ST_OVERTEMP, 1'b1);
      @(posedge clk) hot <= 1'b0;
      t(2);
      ck(1'b1, 1'b1);
      rd(ST);
      fl(fps_pkg::ST_OVERTEMP, 1'b0);
      wr(32'h0000_0000);
      @(posedge clk) hot <= 1'b1;
      t(3);
      ck(1'b0, 1'b1);
      fl(fps_pkg::ST_OVERTEMP, 1'b0);
      @(posedge clk) hot <= 1'b0;
   endtask

   task automatic sc_uv();
      @(posedge clk) di <= 1'b1;
      @(posedge clk) bl <= 1'b1;
      t(2);
      ck(1'b0, 1'b0);
      @(posedge clk) bl <= 1'b0;
      t(3);
      ck(1'b0, 1'b0);
      fl(fps_pkg::ST_UNDERVOLTAGE, 1'b1);
      // The direct input is cycled to release the latch
      @(posedge clk) di <= 1'b0;
      @(posedge clk) di <= 1'b1;
      t(2);
      ck(1'b1, 1'b1);
      @(posedge clk) di <= 1'b0;
      @(posedge clk) bl <= 1'b1;
      t(2);
      @(posedge clk) bl <= 1'b0;
      t(2);
      ck(1'b0, 1'b1);
      fl(fps_pkg::ST_UNDERVOLTAGE, 1'b1);
      fl(fps_pkg::ST_UNDERVOLTAGE, 1'b0);
      wr(32'h0000_0005);
      @(posedge clk) bl <= 1'b1;
      t(3);
      ck(1'b1, 1'b1);
      fl(fps_pkg::ST_UNDERVOLTAGE, 1'b0);
      @(posedge clk) b25 <= 1'b1;
      t(2);
      ck(1'b0, 1'b1);
      @(posedge clk) bl <= 1'b0;
      @(posedge clk) b25 <= 1'b0;
      wr(32'h0000_0000);
   endtask

   task automatic sc_ol();
      @(posedge clk) old <= 1'b1;
      @(posedge clk) gd <= 1'b1;
      t(2);
      ck(1'b0, 1'b0);
      fl(fps_pkg::ST_OPEN_LOAD, 1'b1);
      @(posedge clk) old <= 1'b0;
      t(2);
      ck(1'b0, 1'b1);
      rd(ST);
      fl(fps_pkg::ST_OPEN_LOAD, 1'b0);
      wr(32'h0000_0008);
      @(posedge clk) old <= 1'b1;
      t(3);
      ck(1'b0, 1'b1);
      fl(fps_pkg::ST_OPEN_LOAD, 1'b0);
      @(posedge clk) old <= 1'b0;
      @(posedge clk) gd <= 1'b0;
   endtask

   task automatic sc_oc();
      wr(32'h0000_0001);
      @(posedge clk) hi <= 2'h1;
      t(2);
      ck(1'b0, 1'b0);
      @(posedge clk) hi <= 2'h0;
      t(3);
      ck(1'b0, 1'b0);
      fl(fps_pkg::ST_OVERCURRENT, 1'b1);
      wr(32'h0000_0000);
      wr(32'h0000_0081);
      t(2);
      ck(1'b1, 1'b1);
      @(posedge clk) hi <= 2'h1;
      t(3);
      ck(1'b1, 1'b1);
      @(posedge clk) hi <= 2'h2;
      t(2);
      ck(1'b0, 1'b0);
      @(posedge clk) hi <= 2'h0;
      wr(32'h0000_0000);
      wr(32'h0000_0051);
      @(posedge clk) lo <= 8'hDF;
      t(600);
      ck(1'b1, 1'b1);
      // Blank select 0 gives 500 cycles; margin covers edge alignment
      @(posedge clk) lo <= 8'hFF;
      t(495);
      ck(1'b1, 1'b1);
      t(10);
      ck(1'b0, 1'b0);
      @(posedge clk) lo <= 8'h00;
      wr(32'h0000_0000);
      // Longest blanking: select 3, same low level
      wr(32'h0000_0351);
      @(posedge clk) lo <= 8'hFF;
      t(int'(fps_pkg::BLANK_C3) - 5);
      ck(1'b1, 1'b1);
      t(10);
      ck(1'b0, 1'b0);
      @(posedge clk) lo <= 8'h00;
      wr(32'h0000_0000);
   endtask

   task automatic sc_supply();
      wr(32'h0000_000F);
      @(posedge clk) ok <= 1'b0;
      t(2);
      rd(CT);
      check("ctrl_on_loss", q, fps_pkg::CTRL_RESET);
      @(posedge clk) di <= 1'b1;
      t(2);
      ck(1'b1, 1'b1);
      @(posedge clk) ov <= 1'b1;
      t(2);
      ck(1'b0, 1'b0);
      @(posedge clk) ov <= 1'b0;
      @(posedge clk) di <= 1'b0;
      t(2);
      ck(1'b0, 1'b1);
      @(posedge clk) ok <= 1'b1;
   endtask

   initial
   begin
      {nrst, di, hot, ov, bl, b25, old, gd, lo, hi} = '0;
      ok = 1'b1;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      sc_reset();
      sc_ov();
      sc_ot();
      sc_uv();
      sc_ol();
      sc_oc();
      sc_supply();
      end_sim();
   end
endmodule

`default_nettype wire
